// file: core/omsm_lane.sv
`timescale 1ns/1ps
`include "omsm_regs.svh"
module omsm_lane
   import omsm_pkg::*;
#(
   parameter int N_SLOT = 10,
   parameter int N_SRC = 32
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Sample stream
   input wire logic smp_valid,
   input wire omsm_sample_t [N_SRC-1:0] src_bus,
   input wire logic [15:0] noise_a,
   input wire logic [15:0] noise_b,
   // Settings and results
   omsm_lane_if.lane lif
);

   function automatic omsm_sample_t pick_src(omsm_src_t code, logic muted,
                                              omsm_sample_t [N_SRC-1:0] bus);
      if (muted || code == `OMSM_SRC_NONE || code > `OMSM_SRC_LAST) begin
         return '0;
      end
      return bus[code - `OMSM_SRC_REC_BASE];
   endfunction : pick_src

   function automatic logic [16:0] gain(logic [2:0] rem);
      case (rem)
         3'h1: return `OMSM_GAIN_1;
         3'h2: return `OMSM_GAIN_2;
         3'h3: return `OMSM_GAIN_3;
         3'h4: return `OMSM_GAIN_4;
         3'h5: return `OMSM_GAIN_5;
         default: return `OMSM_GAIN_0;
      endcase
   endfunction : gain

   logic signed [27:0] sum;
   logic all_off;
   logic ovl_pos, ovl_neg;
   omsm_sample_t sat, outv, sat2;
   logic [4:0] shift;
   logic signed [41:0] prod, scaled, pre, q;
   logic signed [17:0] dith;
   logic [23:0] lvl;

   // Ten slots summed at 28 bits so no partial sum can wrap
   always_comb begin
      sum = '0;
      all_off = 1'b1;
      for (int s = 0; s < N_SLOT; s++) begin
         sum = sum + 28'(pick_src(lif.src_sel[s], lif.src_mute[s], src_bus));
         all_off = all_off & (lif.src_mute[s] || lif.src_sel[s] == `OMSM_SRC_NONE);
      end
   end

   assign ovl_pos = sum > 28'(`OMSM_FULL_POS);
   assign ovl_neg = sum < 28'(`OMSM_FULL_NEG);
   assign sat = ovl_pos ? `OMSM_FULL_POS : ovl_neg ? `OMSM_FULL_NEG : sum[23:0];

   // Gain 1.0 at 0 dB keeps the product exact
   assign shift = 5'(lif.atten / `OMSM_DB_PER_SHIFT);
   assign prod = 42'(sat) * $signed({1'b0, gain(3'(lif.atten % `OMSM_DB_PER_SHIFT))});
   assign scaled = prod >>> shift;
   // Difference of two uniforms gives a triangular density
   assign dith = lif.dither ? $signed({2'h0, noise_a}) - $signed({2'h0, noise_b})
                            : 18'sh00000;
   assign pre = scaled + 42'(dith);
   assign q = pre >>> 16;
   assign sat2 = (q > 42'(`OMSM_FULL_POS)) ? `OMSM_FULL_POS :
                 (q < 42'(`OMSM_FULL_NEG)) ? `OMSM_FULL_NEG : q[23:0];
   assign outv = lif.mute ? '0 : sat2;
   assign lvl = outv[23] ? 24'(-outv) : outv;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lif.sample <= '0;
         lif.level <= '0;
         lif.near <= 1'b0;
         lif.applied_db <= `OMSM_ATT_DEF;
      end else if (smp_valid) begin
         lif.sample <= outv;
         lif.level <= lvl;
         lif.near <= lvl >= `OMSM_NEAR_THR;
         lif.applied_db <= lif.atten;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lif.ovl <= 1'b0;
      end else begin
         lif.ovl <= smp_valid && (ovl_pos || ovl_neg);
      end
   end

   default clocking lcb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sat_pos_a: assert property (
      smp_valid && ovl_pos && !lif.mute && !lif.dither && lif.atten == 7'h00
      |=> lif.sample == `OMSM_FULL_POS) else $error("positive sum not saturated");
   sat_neg_a: assert property (
      smp_valid && ovl_neg && !lif.mute && !lif.dither && lif.atten == 7'h00
      |=> lif.sample == `OMSM_FULL_NEG) else $error("negative sum not saturated");
   ovl_flag_a: assert property (
      smp_valid |=> lif.ovl == ($past(ovl_pos) || $past(ovl_neg)))
      else $error("overload pulse wrong");
   mute_out_a: assert property (
      smp_valid && lif.mute |=> lif.sample == '0 && lif.level == '0)
      else $error("muted output not silent");
   unity_pass_a: assert property (
      smp_valid && lif.atten == 7'h00 && !lif.dither && !lif.mute && !ovl_pos && !ovl_neg
      |=> $signed(lif.sample) == $past(sum)) else $error("0 dB path altered");
   no_source_a: assert property (
      smp_valid && all_off && !lif.dither |=> lif.sample == '0)
      else $error("silent slots contributed");
   near_clip_a: assert property (
      smp_valid |=> lif.near == (lif.level >= `OMSM_NEAR_THR))
      else $error("near clip flag wrong");
   applied_db_a: assert property (
      smp_valid |=> lif.applied_db == $past(lif.atten)) else $error("applied dB stale");
   dither_use_c: cover property (smp_valid && lif.dither && lif.atten != 7'h00);
endmodule : omsm_lane

// file: core/omsm_lane_if.sv
`timescale 1ns/1ps
interface omsm_lane_if
   import omsm_pkg::*;
#(
   parameter int N_SLOT = 10
);
   omsm_src_t [N_SLOT-1:0] src_sel;
   logic [N_SLOT-1:0] src_mute;
   logic [6:0] atten;
   logic mute;
   logic dither;
   omsm_sample_t sample;
   logic ovl;
   logic [23:0] level;
   logic near;
   logic [6:0] applied_db;
   modport cfg (
      output src_sel, src_mute, atten, mute, dither,
      input sample, ovl, level, near, applied_db
   );
   modport lane (
      input src_sel, src_mute, atten, mute, dither,
      output sample, ovl, level, near, applied_db
   );
endinterface : omsm_lane_if

// file: core/omsm_pkg.sv
package omsm_pkg;
   typedef logic signed [23:0] omsm_sample_t;
   typedef logic [5:0] omsm_src_t;
   typedef enum logic [2:0] {
      OMSM_R_CTRL,
      OMSM_R_OVL,
      OMSM_R_NEAR,
      OMSM_R_OUTCTL,
      OMSM_R_ATTDB,
      OMSM_R_PEAK,
      OMSM_R_SLOT,
      OMSM_R_NONE
   } omsm_reg_e;
   typedef struct packed {
      omsm_reg_e kind;
      logic [3:0] oidx;
      logic [3:0] sidx;
   } omsm_dec_s;
endpackage : omsm_pkg

// file: core/omsm_regs.svh
`ifndef OMSM_REGS_SVH
`define OMSM_REGS_SVH

// Register byte offsets and address pages
`define OMSM_CTRL_OFS 12'h000
`define OMSM_OVL_OFS 12'h004
`define OMSM_NEAR_OFS 12'h008
`define OMSM_OUTCTL_PAGE 6'h04
`define OMSM_ATTDB_PAGE 6'h05
`define OMSM_PEAK_PAGE 6'h06
`define OMSM_SLOT_PAGE 2'h1

// Field positions
`define OMSM_CTRL_RESTORE_BIT 0
`define OMSM_OUTCTL_MUTE_BIT 8
`define OMSM_OUTCTL_DITHER_BIT 9
`define OMSM_SLOT_MUTE_BIT 8

// Reset values
`define OMSM_ATT_DEF 7'h00
`define OMSM_LFSR_SEED 48'h5a3c_96e1_0f7d

// Source codes
`define OMSM_SRC_NONE 6'h00
`define OMSM_SRC_REC_BASE 6'h01
`define OMSM_SRC_PLAY_BASE 6'h11
`define OMSM_SRC_LAST 6'h20

// Levels: full scale and full scale less 16 dB
`define OMSM_FULL_POS 24'sh7fffff
`define OMSM_FULL_NEG 24'sh800000
`define OMSM_NEAR_THR 24'h14496e

// Attenuation: one shift per 6 dB, remainder from a gain table
`define OMSM_DB_PER_SHIFT 7'h06
`define OMSM_GAIN_0 17'h10000
`define OMSM_GAIN_1 17'h0e412
`define OMSM_GAIN_2 17'h0cb30
`define OMSM_GAIN_3 17'h0b505
`define OMSM_GAIN_4 17'h0a145
`define OMSM_GAIN_5 17'h08fad

// AXI responses
`define OMSM_RESP_OKAY 2'h0
`define OMSM_RESP_SLVERR 2'h2

`endif

// file: core/omsm_top.sv
`timescale 1ns/1ps
`include "omsm_regs.svh"
// Behaviour
// - Sixteen outputs, each summing ten sources
// - Slot picks record channel or play channel
// - No-source slot adds nothing
// - Record choices carry currently patched inputs
// - Per-slot mute drops that source
// - Overload flagged when sum exceeds full scale
// - Fader attenuation; maximum passes stream unaltered with dither off
// - Applied attenuation readable in decibels
// - Peak tracked; flag within 16 dB
// - Output mute silences the channel
// - Per-output triangular dither enable
// - Restore returns all settings to defaults
module omsm_top
   import omsm_pkg::*;
#(
   parameter int N_OUT = 16,
   parameter int N_SLOT = 10,
   parameter int N_REC = 16,
   parameter int N_PLAY = 16
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Sources, one strobe per sample period
   input wire logic smp_valid,
   input wire omsm_sample_t [N_REC-1:0] rec_bus,
   input wire omsm_sample_t [N_PLAY-1:0] play_bus,
   // Outputs
   output logic out_valid,
   output omsm_sample_t [N_OUT-1:0] out_bus,
   output logic [N_OUT-1:0] overload,
   output logic [N_OUT-1:0] near_clip
);

   // Settings
   omsm_src_t [N_SLOT-1:0] slot_src [N_OUT];
   logic [N_SLOT-1:0] slot_mute [N_OUT];
   logic [6:0] out_att [N_OUT];
   logic [N_OUT-1:0] out_mute;
   logic [N_OUT-1:0] out_dith;

   // Lane results and status
   logic [N_OUT-1:0] ovl_vec;
   logic [N_OUT-1:0] near_vec;
   logic [N_OUT-1:0] ovl_sticky;
   logic [N_OUT-1:0] ovl_clr;
   logic [N_OUT-1:0] ovl_keep;
   logic [N_OUT-1:0] peak_clr;
   logic [23:0] lane_level [N_OUT];
   logic [6:0] lane_db [N_OUT];
   logic [23:0] peak [N_OUT];
   logic [47:0] lfsr;

   // Bus state
   logic aw_held, w_held;
   logic [11:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic wr_fire, rd_fire, restore;
   omsm_dec_s wr_dec, rd_dec;
   logic [31:0] wr_merged;
   logic [31:0] rd_word;

   function automatic omsm_dec_s decode(logic [11:0] a);
      omsm_dec_s d;
      d.kind = OMSM_R_NONE;
      d.oidx = a[5:2];
      d.sidx = 4'h0;
      if (a[1:0] != 2'h0) begin
         d.kind = OMSM_R_NONE;
      end else if (a == `OMSM_CTRL_OFS) begin
         d.kind = OMSM_R_CTRL;
      end else if (a == `OMSM_OVL_OFS) begin
         d.kind = OMSM_R_OVL;
      end else if (a == `OMSM_NEAR_OFS) begin
         d.kind = OMSM_R_NEAR;
      end else if (a[11:6] == `OMSM_OUTCTL_PAGE) begin
         d.kind = OMSM_R_OUTCTL;
      end else if (a[11:6] == `OMSM_ATTDB_PAGE) begin
         d.kind = OMSM_R_ATTDB;
      end else if (a[11:6] == `OMSM_PEAK_PAGE) begin
         d.kind = OMSM_R_PEAK;
      end else if (a[11:10] == `OMSM_SLOT_PAGE && a[5:2] < 4'(N_SLOT)) begin
         d.kind = OMSM_R_SLOT;
         d.oidx = a[9:6];
         d.sidx = a[5:2];
      end
      return d;
   endfunction : decode

   // Readback value, also the base for byte-lane merges on write
   function automatic logic [31:0] reg_word(omsm_dec_s d);
      logic [31:0] v;
      v = '0;
      case (d.kind)
         OMSM_R_OVL: v[N_OUT-1:0] = ovl_sticky;
         OMSM_R_NEAR: v[N_OUT-1:0] = near_vec;
         OMSM_R_OUTCTL: begin
            v[6:0] = out_att[d.oidx];
            v[`OMSM_OUTCTL_MUTE_BIT] = out_mute[d.oidx];
            v[`OMSM_OUTCTL_DITHER_BIT] = out_dith[d.oidx];
         end
         OMSM_R_ATTDB: v[6:0] = lane_db[d.oidx];
         OMSM_R_PEAK: v[23:0] = peak[d.oidx];
         OMSM_R_SLOT: begin
            v[5:0] = slot_src[d.oidx][d.sidx];
            v[`OMSM_SLOT_MUTE_BIT] = slot_mute[d.oidx][d.sidx];
         end
         default: v = '0;
      endcase
      return v;
   endfunction : reg_word

   function automatic logic [31:0] wmerge(logic [31:0] old, logic [31:0] data,
                                          logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = data[b*8 +: 8];
         end
      end
      return r;
   endfunction : wmerge

   // Write address and data may arrive in either order
   assign s_axi_awready = ~aw_held;
   assign s_axi_wready = ~w_held;
   assign wr_fire = aw_held && w_held && !s_axi_bvalid;
   assign wr_dec = decode(aw_addr_q);
   // Process, so the merge base follows every register that reg_word reads
   always_comb begin
      wr_merged = wmerge(reg_word(wr_dec), w_data_q, w_strb_q);
   end
   assign restore = wr_fire && wr_dec.kind == OMSM_R_CTRL
                    && wr_merged[`OMSM_CTRL_RESTORE_BIT];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         aw_addr_q <= 12'h000;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         aw_addr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held <= 1'b0;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held <= 1'b1;
         w_data_q <= s_axi_wdata;
         w_strb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_held <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `OMSM_RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (wr_dec.kind == OMSM_R_NONE) ? `OMSM_RESP_SLVERR : `OMSM_RESP_OKAY;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Settings: reset and restore share one path so defaults cannot diverge
   always_ff @(posedge aclk) begin
      if (!aresetn || restore) begin
         for (int o = 0; o < N_OUT; o++) begin
            slot_src[o] <= '0;
            slot_src[o][0] <= 6'(`OMSM_SRC_PLAY_BASE + o);
            slot_mute[o] <= '0;
            out_att[o] <= `OMSM_ATT_DEF;
         end
         out_mute <= '0;
         out_dith <= '0;
      end else if (wr_fire) begin
         case (wr_dec.kind)
            OMSM_R_OUTCTL: begin
               out_att[wr_dec.oidx] <= wr_merged[6:0];
               out_mute[wr_dec.oidx] <= wr_merged[`OMSM_OUTCTL_MUTE_BIT];
               out_dith[wr_dec.oidx] <= wr_merged[`OMSM_OUTCTL_DITHER_BIT];
            end
            OMSM_R_SLOT: begin
               slot_src[wr_dec.oidx][wr_dec.sidx] <= wr_merged[5:0];
               slot_mute[wr_dec.oidx][wr_dec.sidx] <= wr_merged[`OMSM_SLOT_MUTE_BIT];
            end
            default: ;
         endcase
      end
   end

   // Overload: write one to clear, a new event in the same cycle wins
   assign ovl_clr = (wr_fire && wr_dec.kind == OMSM_R_OVL) ? wr_merged[N_OUT-1:0] : '0;
   assign ovl_keep = ovl_sticky & ~ovl_clr;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ovl_sticky <= '0;
      end else begin
         ovl_sticky <= ovl_keep | ovl_vec;
      end
   end

   // Reads: one outstanding, answered the cycle after the address is taken
   assign s_axi_arready = ~s_axi_rvalid;
   assign rd_fire = s_axi_arvalid && s_axi_arready;
   assign rd_dec = decode(s_axi_araddr);

   always_comb begin
      rd_word = reg_word(rd_dec);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `OMSM_RESP_OKAY;
      end else if (rd_fire) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word;
         s_axi_rresp <= (rd_dec.kind == OMSM_R_NONE) ? `OMSM_RESP_SLVERR : `OMSM_RESP_OKAY;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Shared noise source; each lane takes a different window of it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lfsr <= `OMSM_LFSR_SEED;
      end else if (smp_valid) begin
         lfsr <= {lfsr[46:0], lfsr[47] ^ lfsr[46] ^ lfsr[20] ^ lfsr[19]};
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         out_valid <= 1'b0;
      end else begin
         out_valid <= smp_valid;
      end
   end

   assign overload = ovl_sticky;
   assign near_clip = near_vec;

   generate
      for (genvar g = 0; g < N_OUT; g++) begin : g_out
         omsm_lane_if #(.N_SLOT(N_SLOT)) lif ();

         assign lif.src_sel = slot_src[g];
         assign lif.src_mute = slot_mute[g];
         assign lif.atten = out_att[g];
         assign lif.mute = out_mute[g];
         assign lif.dither = out_dith[g];
         assign out_bus[g] = lif.sample;
         assign ovl_vec[g] = lif.ovl;
         assign near_vec[g] = lif.near;
         assign lane_level[g] = lif.level;
         assign lane_db[g] = lif.applied_db;
         assign peak_clr[g] = rd_fire && rd_dec.kind == OMSM_R_PEAK
                              && rd_dec.oidx == 4'(g);

         // Record bus is already patched upstream, so codes follow the patch
         omsm_lane #(
            .N_SLOT(N_SLOT),
            .N_SRC(N_REC + N_PLAY)
         ) u_lane (
            .aclk(aclk),
            .aresetn(aresetn),
            .smp_valid(smp_valid),
            .src_bus({play_bus, rec_bus}),
            .noise_a(lfsr[g +: 16]),
            .noise_b(lfsr[g + 16 +: 16]),
            .lif(lif.lane)
         );

         // Peak hold, cleared by reading it; a new sample in that cycle wins
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               peak[g] <= 24'h000000;
            end else if (out_valid && (peak_clr[g] || lane_level[g] > peak[g])) begin
               peak[g] <= lane_level[g];
            end else if (peak_clr[g]) begin
               peak[g] <= 24'h000000;
            end
         end
      end
   endgenerate

   default clocking tcb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   restore_def_a: assert property (
      restore |=> out_att[0] == `OMSM_ATT_DEF && out_mute == '0 && out_dith == '0
      && slot_src[1][0] == 6'(`OMSM_SRC_PLAY_BASE + 1) && slot_mute[1] == '0)
      else $error("restore left a setting changed");
   ovl_sticky_a: assert property (
      (ovl_vec != '0) |=> (ovl_sticky & $past(ovl_vec)) == $past(ovl_vec))
      else $error("overload event lost");
   ovl_keep_a: assert property (
      (ovl_keep != '0) |=> (ovl_sticky & $past(ovl_keep)) == $past(ovl_keep))
      else $error("overload dropped without a clear");
   out_step_a: assert property (
      smp_valid |=> out_valid ##1 !out_valid || $past(smp_valid))
      else $error("output strobe not one cycle after sample");
   bus_hold_a: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   read_lat_a: assert property (
      rd_fire |=> s_axi_rvalid && s_axi_rdata == $past(rd_word))
      else $error("read answer late or wrong");

   restore_c: cover property (restore);
   overload_c: cover property (ovl_vec != '0 ##1 ovl_clr != '0);
   near_clip_c: cover property (near_vec != '0);
   peak_read_c: cover property (peak_clr != '0 && out_valid);
endmodule : omsm_top

// file: test/omsm_bench.sv
`timescale 1ns/1ps
`include "omsm_regs.svh"
module omsm_bench
   import omsm_pkg::*;
;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [11:0] s_axi_awaddr = '0;
   logic [11:0] s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic smp_valid, out_valid;
   omsm_sample_t [15:0] rec_bus, play_bus, out_bus;
   logic [15:0] overload, near_clip;
   int miscompares = 0;
   int compares = 0;
   int cycles = 0;
   omsm_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .smp_valid(smp_valid), .rec_bus(rec_bus),
      .play_bus(play_bus), .out_valid(out_valid), .out_bus(out_bus),
      .overload(overload), .near_clip(near_clip));
   omsm_src_model src_u (.aclk(aclk), .smp_valid(smp_valid), .rec_bus(rec_bus),
      .play_bus(play_bus));
   initial begin
      forever #20 aclk = ~aclk;
   end
   task automatic summarize();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : summarize
   // Ceiling well above the hundred-odd cycles the sequence needs
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares++;
         summarize();
      end
   end
   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk32
   task automatic chk_smp(input omsm_sample_t got, input omsm_sample_t exp);
      chk32({8'h00, got}, {8'h00, exp});
   endtask : chk_smp
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw_ok;
      logic w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (!aw_ok && s_axi_awready) begin
            aw_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_ok && s_axi_wready) begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
         if (s_axi_bvalid) begin
            chk32({30'h0, s_axi_bresp}, {30'h0, er});
            s_axi_bready <= 1'b0;
            break;
         end
      end
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            chk32(s_axi_rdata, ed);
            chk32({30'h0, s_axi_rresp}, {30'h0, er});
            s_axi_rready <= 1'b0;
            break;
         end
      end
   endtask : rd
   task automatic smp(input omsm_sample_t p0);
      src_u.play_v[0] = p0;
      src_u.send();
      @(negedge aclk);
      chk32({31'h0, out_valid}, 32'h1);
   endtask : smp
   function automatic logic [11:0] slot_a(input int s);
      return 12'(12'h400 + s * 4);
   endfunction : slot_a
   initial begin
      omsm_sample_t e;
      omsm_sample_t d;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      rd(slot_a(0), 32'h11, 2'h0);
      rd(slot_a(1), 32'h0, 2'h0);
      rd(12'h100, 32'h0, 2'h0);
      for (int i = 0; i < 16; i++) begin
         src_u.play_v[i] = {4'h0, 4'(i), 16'h1234};
         src_u.rec_v[i] = {4'hf, 4'(i), 16'h8000};
      end
      smp(src_u.play_v[0]);
      for (int o = 0; o < 16; o++) chk_smp(out_bus[o], src_u.play_v[o]);
      wr(slot_a(1), 32'h06, 2'h0);
      wr(slot_a(2), 32'h20, 2'h0);
      wr(slot_a(3), 32'h21, 2'h0);
      wr(slot_a(4), 32'h00, 2'h0);
      smp(src_u.play_v[0]);
      e = src_u.play_v[0] + src_u.rec_v[5] + src_u.play_v[15];
      chk_smp(out_bus[0], e);
      wr(slot_a(2), 32'h120, 2'h0);
      smp(src_u.play_v[0]);
      e = src_u.play_v[0] + src_u.rec_v[5];
      chk_smp(out_bus[0], e);
      // Two sources mixed, so dither is turned on
      wr(12'h100, 32'h200, 2'h0);
      repeat (4) begin
         smp(src_u.play_v[0]);
         d = out_bus[0] - e;
         chk32({31'h0, d >= -1 && d <= 1}, 32'h1);
      end
      wr(`OMSM_CTRL_OFS, 32'h1, 2'h0);
      rd(slot_a(1), 32'h0, 2'h0);
      rd(slot_a(2), 32'h0, 2'h0);
      rd(12'h100, 32'h0, 2'h0);
      wr(slot_a(1), 32'h11, 2'h0);
      smp(24'sh600000);
      chk_smp(out_bus[0], `OMSM_FULL_POS);
      // Sticky bit lands one edge after the lane pulse
      @(negedge aclk);
      chk32({31'h0, overload[0]}, 32'h1);
      chk32({31'h0, near_clip[0]}, 32'h1);
      smp(-24'sh600000);
      chk_smp(out_bus[0], `OMSM_FULL_NEG);
      smp(24'sh001000);
      chk_smp(out_bus[0], 24'sh002000);
      chk32({31'h0, overload[0]}, 32'h1);
      chk32({31'h0, near_clip[0]}, 32'h0);
      rd(`OMSM_OVL_OFS, 32'h1, 2'h0);
      wr(`OMSM_OVL_OFS, 32'h1, 2'h0);
      rd(`OMSM_OVL_OFS, 32'h0, 2'h0);
      chk32({31'h0, overload[0]}, 32'h0);
      // Largest level since reset is the full negative sample
      rd(12'h180, 32'h0080_0000, 2'h0);
      smp(24'sh100000);
      smp(-24'sh080000);
      rd(12'h180, 32'h200000, 2'h0);
      rd(`OMSM_NEAR_OFS, 32'h0, 2'h0);
      wr(12'h100, 32'h6, 2'h0);
      smp(24'sh080000);
      chk_smp(out_bus[0], 24'sh080000);
      rd(12'h140, 32'h6, 2'h0);
      wr(12'h100, 32'h100, 2'h0);
      smp(24'sh080000);
      chk_smp(out_bus[0], 24'sh000000);
      chk_smp(out_bus[1], src_u.play_v[1]);
      // Only byte lane 0 written; mute in lane 1 must survive
      s_axi_wstrb <= 4'h1;
      wr(12'h100, 32'hffff_ff0c, 2'h0);
      s_axi_wstrb <= 4'hf;
      rd(12'h100, 32'h10c, 2'h0);
      rd(12'h010, 32'h0, 2'h2);
      wr(12'h428, 32'h5, 2'h2);
      summarize();
   end
endmodule : omsm_bench

// file: test/omsm_src_model.sv
`timescale 1ns/1ps
module omsm_src_model
   import omsm_pkg::*;
#(
   parameter int N_REC = 16,
   parameter int N_PLAY = 16
) (
   // Clock
   input wire logic aclk,
   // Source stream
   output logic smp_valid,
   output omsm_sample_t [N_REC-1:0] rec_bus,
   output omsm_sample_t [N_PLAY-1:0] play_bus
);
   omsm_sample_t [N_REC-1:0] rec_v = '0;
   omsm_sample_t [N_PLAY-1:0] play_v = '0;
   logic strobe_q = 1'b0;
   // Buses mean nothing outside the strobe, so show junk there
   assign smp_valid = strobe_q;
   assign rec_bus = strobe_q ? rec_v : ~rec_v;
   assign play_bus = strobe_q ? play_v : ~play_v;
   task automatic send();
      @(posedge aclk);
      strobe_q <= 1'b1;
      @(posedge aclk);
      strobe_q <= 1'b0;
   endtask : send
endmodule : omsm_src_model
